// [xmo_pkg.sv]
// package: opcodes, flag positions, reset values and timing for the extended memory-op execute block
package xmo_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 12;
   // flag vector bit positions
   localparam int FLAG_C  = 0;
   localparam int FLAG_AC = 1;
   localparam int FLAG_Z  = 2;
   localparam int FLAG_OV = 3;
   localparam int FLAG_SC = 4;
   localparam int FLAG_CZ = 5;
   localparam int FLAG_W  = 6;
   localparam logic [7:0] ACC_RESET   = 8'h00;
   localparam logic [5:0] FLAGS_RESET = 6'h00;
   localparam logic [7:0] ALL_ONES    = 8'hff;
   // cycles spent by a skip-taken instruction
   localparam int SKIP_CYCLES = 3;
   typedef enum logic [4:0] {
      OP_NOP        = 5'h00,
      OP_ROL        = 5'h01,
      OP_ROL_A      = 5'h02,
      OP_ROLC       = 5'h03,
      OP_ROLC_A     = 5'h04,
      OP_ROR        = 5'h05,
      OP_ROR_A      = 5'h06,
      OP_RORC       = 5'h07,
      OP_RORC_A     = 5'h08,
      OP_SBC_A      = 5'h09,
      OP_SBC_M      = 5'h0a,
      OP_SUB_A      = 5'h0b,
      OP_SUB_M      = 5'h0c,
      OP_DECSZ      = 5'h0d,
      OP_DECSZ_A    = 5'h0e,
      OP_INCSZ      = 5'h0f,
      OP_INCSZ_A    = 5'h10,
      OP_SET        = 5'h11,
      OP_SETBIT     = 5'h12,
      OP_SNZBIT     = 5'h13,
      OP_SNZ        = 5'h14,
      OP_SWAP       = 5'h15,
      OP_SWAP_A     = 5'h16,
      OP_ORM        = 5'h17
   } xmo_op_type;
   typedef enum logic [2:0] {
      ST_EXEC  = 3'b001,
      ST_DUMMY = 3'b010,
      ST_HOLD  = 3'b100
   } xmo_state_type;
endpackage

// [xmo_arith.sv]
`timescale 1ns/1ps
// subtract unit: difference and the six arithmetic flags
module xmo_arith #(
   parameter int WIDTH = 8
) (
   // operands
   input  wire logic [WIDTH-1:0] minuend,
   input  wire logic [WIDTH-1:0] subtrahend,
   input  wire logic             borrowIn,
   input  wire logic             zeroIn,
   // results
   output logic      [WIDTH-1:0] diff,
   output logic                  carryOut,
   output logic                  nibbleCarry,
   output logic                  zeroOut,
   output logic                  signedWrap,
   output logic                  signedCompare,
   output logic                  chainedZero
);
   if (WIDTH < 8) begin : widthCheck
      $error("xmo_arith needs at least 8 bits");
   end
   logic [WIDTH:0] wide;
   logic [4:0]     low;
   always_comb begin
      wide = {1'b0, minuend} - {1'b0, subtrahend} - {{WIDTH{1'b0}}, borrowIn};
      low  = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrowIn};
      diff = wide[WIDTH-1:0];
      // carry set when no borrow occurred (result positive or zero)
      carryOut    = ~wide[WIDTH];
      nibbleCarry = ~low[4];
      zeroOut     = (diff == '0);
      signedWrap  = (minuend[WIDTH-1] ^ subtrahend[WIDTH-1]) & (minuend[WIDTH-1] ^ diff[WIDTH-1]);
      signedCompare = diff[WIDTH-1] ^ signedWrap;
      // zero across a multi-byte chain: previous zero and this byte zero
      chainedZero = zeroOut & zeroIn;
   end
endmodule

// [xmo_execute.sv]
`timescale 1ns/1ps
// extended memory-op execute stage: rotate, subtract, skip, set, swap and OR-to-memory
// What this block does
// - plain rotate left moves bit 7 into bit 0, memory or accumulator, no flags
// - rotate left through carry: bit 7 into carry, old carry into bit 0
// - plain rotate right moves bit 0 into bit 7, memory or accumulator, no flags
// - rotate right through carry: bit 0 into carry, old carry into bit 7
// - accumulator forms of rotate, skip-count and swap never write data memory
// - subtract with borrow to accumulator: acc minus byte minus inverted carry, six flags
// - memory form of subtract with borrow writes difference back to the byte
// - plain subtract to accumulator or memory, carry set unless negative, six flags
// - decrement writes byte minus one to memory, skips on zero, three cycles
// - accumulator decrement loads byte minus one, memory intact, skips on zero
// - increment writes byte plus one to memory, skips on zero, three cycles
// - accumulator increment loads byte plus one, memory intact, skips on zero
// - set byte writes all ones to memory, flags untouched
// - set bit drives only the selected bit to one, flags untouched
// - skip if selected bit is one, three cycles, no flags
// - skip if byte nonzero, byte written back unchanged, no flags
// - nibble swap in memory exchanges high and low nibbles, no flags
// - accumulator nibble swap loads swapped byte into accumulator only
// - OR into memory writes acc OR byte to memory, updates zero flag only
// - full-width address reaches any data memory section, no bank limit
module xmo_execute #(
   parameter int ADDR_BITS = xmo_pkg::ADDR_W
) (
   // clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   sys_rst,
   // decoded instruction
   input  wire logic                   opValid,
   input  wire xmo_pkg::xmo_op_type    opCode,
   input  wire logic [2:0]             bitSel,
   input  wire logic [ADDR_BITS-1:0]   memAddr,
   // operand read from data memory
   input  wire logic [7:0]             memRdData,
   // data memory write port
   output logic                        memWrEn,
   output logic [ADDR_BITS-1:0]        memWrAddr,
   output logic [7:0]                  memWrData,
   // core state
   output logic [7:0]                  accOut,
   output logic [5:0]                  flagsOut,
   // pipeline control
   output logic                        squashNext,
   output logic                        busy
);
   import xmo_pkg::*;

   // widths the write port cannot carry are refused at elaboration
   if (ADDR_BITS < 1 || ADDR_BITS > 16) begin : addrWidthCheck
      $error("xmo_execute address width out of range");
   end

   logic [7:0]           accReg;
   logic [5:0]           flagReg;
   logic                 memWrEnReg;
   logic [ADDR_BITS-1:0] memWrAddrReg;
   logic [7:0]           memWrDataReg;
   logic                 squashReg;
   logic                 busyReg;
   xmo_state_type        stateReg;
   xmo_state_type        stateNext;

   logic [7:0]           accNext;
   logic [5:0]           flagNext;
   logic                 wrNext;
   logic [7:0]           wrDataNext;
   logic                 skipNext;

   function automatic logic [7:0] swapNib(input logic [7:0] v);
      swapNib = {v[3:0], v[7:4]};
   endfunction

   // subtract unit shared by all four subtract forms
   logic       useBorrow;
   logic [7:0] subDiff;
   logic       subC;
   logic       subAc;
   logic       subZ;
   logic       subOv;
   logic       subSc;
   logic       subCz;
   assign useBorrow = (opCode == OP_SBC_A) || (opCode == OP_SBC_M);

   xmo_arith #(
      .WIDTH(DATA_W)
   ) subUnit (
      .minuend       (accReg),
      .subtrahend    (memRdData),
      .borrowIn      (useBorrow & ~flagReg[FLAG_C]),
      .zeroIn        (useBorrow ? flagReg[FLAG_Z] : 1'b1),
      .diff          (subDiff),
      .carryOut      (subC),
      .nibbleCarry   (subAc),
      .zeroOut       (subZ),
      .signedWrap    (subOv),
      .signedCompare (subSc),
      .chainedZero   (subCz)
   );

   logic [7:0] decVal;
   logic [7:0] incVal;
   logic [7:0] orVal;
   assign decVal = memRdData - 8'h01;
   assign incVal = memRdData + 8'h01;
   assign orVal  = accReg | memRdData;

   // operation decode: next accumulator, flags, write and skip
   always_comb begin
      accNext    = accReg;
      flagNext   = flagReg;
      wrNext     = 1'b0;
      wrDataNext = memRdData;
      skipNext   = 1'b0;
      case (opCode)
         OP_ROL: begin
            wrNext     = 1'b1;
            wrDataNext = {memRdData[6:0], memRdData[7]};
         end
         OP_ROL_A: begin
            accNext = {memRdData[6:0], memRdData[7]};
         end
         OP_ROLC: begin
            wrNext            = 1'b1;
            wrDataNext        = {memRdData[6:0], flagReg[FLAG_C]};
            flagNext[FLAG_C]  = memRdData[7];
         end
         OP_ROLC_A: begin
            accNext           = {memRdData[6:0], flagReg[FLAG_C]};
            flagNext[FLAG_C]  = memRdData[7];
         end
         OP_ROR: begin
            wrNext     = 1'b1;
            wrDataNext = {memRdData[0], memRdData[7:1]};
         end
         OP_ROR_A: begin
            accNext = {memRdData[0], memRdData[7:1]};
         end
         OP_RORC: begin
            wrNext            = 1'b1;
            wrDataNext        = {flagReg[FLAG_C], memRdData[7:1]};
            flagNext[FLAG_C]  = memRdData[0];
         end
         OP_RORC_A: begin
            accNext           = {flagReg[FLAG_C], memRdData[7:1]};
            flagNext[FLAG_C]  = memRdData[0];
         end
         OP_SBC_A, OP_SUB_A: begin
            accNext  = subDiff;
            flagNext = {subCz, subSc, subOv, subZ, subAc, subC};
         end
         OP_SBC_M, OP_SUB_M: begin
            wrNext     = 1'b1;
            wrDataNext = subDiff;
            flagNext   = {subCz, subSc, subOv, subZ, subAc, subC};
         end
         OP_DECSZ: begin
            wrNext     = 1'b1;
            wrDataNext = decVal;
            skipNext   = (decVal == 8'h00);
         end
         OP_DECSZ_A: begin
            accNext  = decVal;
            skipNext = (decVal == 8'h00);
         end
         OP_INCSZ: begin
            wrNext     = 1'b1;
            wrDataNext = incVal;
            skipNext   = (incVal == 8'h00);
         end
         OP_INCSZ_A: begin
            accNext  = incVal;
            skipNext = (incVal == 8'h00);
         end
         OP_SET: begin
            wrNext     = 1'b1;
            wrDataNext = ALL_ONES;
         end
         OP_SETBIT: begin
            wrNext             = 1'b1;
            wrDataNext[bitSel] = 1'b1;
         end
         OP_SNZBIT: begin
            skipNext = memRdData[bitSel];
         end
         OP_SNZ: begin
            wrNext   = 1'b1;
            skipNext = (memRdData != 8'h00);
         end
         OP_SWAP: begin
            wrNext     = 1'b1;
            wrDataNext = swapNib(memRdData);
         end
         OP_SWAP_A: begin
            accNext = swapNib(memRdData);
         end
         OP_ORM: begin
            wrNext           = 1'b1;
            wrDataNext       = orVal;
            flagNext[FLAG_Z] = (orVal == 8'h00);
         end
         default: begin
            accNext = accReg;
         end
      endcase
   end

   // an instruction executes only in the normal state; the hold and dummy cycles discard it
   logic doExec;
   assign doExec = opValid && (stateReg == ST_EXEC);

   // sequencer: exec, then two extra cycles when a skip is taken
   always_comb begin
      case (stateReg)
         ST_EXEC:  stateNext = (doExec && skipNext) ? ST_HOLD : ST_EXEC;
         ST_HOLD:  stateNext = ST_DUMMY;
         ST_DUMMY: stateNext = ST_EXEC;
         default:  stateNext = ST_EXEC;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         stateReg <= ST_EXEC;
      end else begin
         stateReg <= stateNext;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         accReg  <= ACC_RESET;
         flagReg <= FLAGS_RESET;
      end else if (doExec) begin
         accReg  <= accNext;
         flagReg <= flagNext;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         memWrEnReg   <= 1'b0;
         memWrAddrReg <= '0;
         memWrDataReg <= 8'h00;
      end else begin
         memWrEnReg   <= doExec && wrNext;
         memWrAddrReg <= memAddr;
         memWrDataReg <= wrDataNext;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         squashReg <= 1'b0;
      end else begin
         squashReg <= (doExec && skipNext) || (stateReg == ST_HOLD);
      end
   end

   // busy comes from its own flop so the core sees no decode path behind it
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         busyReg <= 1'b0;
      end else begin
         busyReg <= (stateNext != ST_EXEC);
      end
   end

   assign memWrEn    = memWrEnReg;
   assign memWrAddr  = memWrAddrReg;
   assign memWrData  = memWrDataReg;
   assign accOut     = accReg;
   assign flagsOut   = flagReg;
   assign squashNext = squashReg;
   assign busy       = busyReg;

   // checks
   skip_timing_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (doExec && skipNext) |=> busy [*2] ##1 !busy)
      else $error("skip did not take three cycles");
   acc_form_nowrite_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (doExec && (opCode == OP_ROL_A || opCode == OP_ROLC_A || opCode == OP_ROR_A || opCode == OP_RORC_A
         || opCode == OP_DECSZ_A || opCode == OP_INCSZ_A || opCode == OP_SWAP_A)) |=> !memWrEn)
      else $error("accumulator form wrote memory");
   dummy_squash_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      busy |=> !memWrEn && $stable(accOut) && $stable(flagsOut))
      else $error("side effect during dummy cycle");
   rotl_value_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (doExec && opCode == OP_ROL) |=> memWrEn && memWrData == {$past(memRdData[6:0]), $past(memRdData[7])})
      else $error("rotate left data wrong");
   rolc_acc_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (doExec && opCode == OP_ROLC_A) |=> accOut == {$past(memRdData[6:0]), $past(flagsOut[FLAG_C])}
         && flagsOut[FLAG_C] == $past(memRdData[7]) && !memWrEn)
      else $error("rotate left through carry wrong");
   rotr_value_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (doExec && opCode == OP_ROR) |=> memWrEn && memWrData == {$past(memRdData[0]), $past(memRdData[7:1])}
         && $stable(flagsOut))
      else $error("rotate right data wrong");
   rorc_carry_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (doExec && opCode == OP_RORC) |=> flagsOut[FLAG_C] == $past(memRdData[0])
         && memWrData[7] == $past(flagsOut[FLAG_C]))
      else $error("rotate right carry wrong");
   sbc_acc_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (doExec && opCode == OP_SBC_A)
         |=> accOut == $past(accOut) - $past(memRdData) - {7'h00, ~$past(flagsOut[FLAG_C])})
      else $error("subtract with borrow to accumulator wrong");
   sbc_mem_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (doExec && opCode == OP_SBC_M) |=> memWrEn && $stable(accOut)
         && memWrData == $past(accOut) - $past(memRdData) - {7'h00, ~$past(flagsOut[FLAG_C])})
      else $error("subtract with borrow to memory wrong");
   sub_carry_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (doExec && opCode == OP_SUB_A) |=> flagsOut[FLAG_C] == ($past(accOut) >= $past(memRdData)))
      else $error("subtract carry wrong");
   sub_mem_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (doExec && opCode == OP_SUB_M) |=> memWrEn && memWrData == $past(accOut) - $past(memRdData)
         && flagsOut[FLAG_C] == ($past(accOut) >= $past(memRdData)))
      else $error("subtract to memory wrong");
   dec_skip_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (doExec && opCode == OP_DECSZ) |=> squashNext == ($past(memRdData) == 8'h01))
      else $error("decrement skip decision wrong");
   acc_dec_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (doExec && opCode == OP_DECSZ_A) |=> !memWrEn && accOut == $past(memRdData) - 8'h01
         && squashNext == ($past(memRdData) == 8'h01) && $stable(flagsOut))
      else $error("accumulator decrement wrong");
   inc_skip_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (doExec && opCode == OP_INCSZ) |=> memWrEn && memWrData == $past(memRdData) + 8'h01
         && squashNext == ($past(memRdData) == 8'hff) && $stable(flagsOut))
      else $error("increment skip wrong");
   acc_inc_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (doExec && opCode == OP_INCSZ_A) |=> !memWrEn && accOut == $past(memRdData) + 8'h01
         && squashNext == ($past(memRdData) == 8'hff) && $stable(flagsOut))
      else $error("accumulator increment wrong");
   set_byte_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (doExec && opCode == OP_SET) |=> memWrEn && memWrData == 8'hff && $stable(flagsOut))
      else $error("set byte wrong");
   set_bit_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (doExec && opCode == OP_SETBIT) |=> memWrEn && $stable(flagsOut)
         && memWrData == ($past(memRdData) | (8'h01 << $past(bitSel))))
      else $error("set bit wrong");
   bit_skip_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (doExec && opCode == OP_SNZBIT) |=> squashNext == $past(memRdData[bitSel]) && !memWrEn)
      else $error("bit skip decision wrong");
   nonzero_skip_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (doExec && opCode == OP_SNZ) |=> memWrEn && memWrData == $past(memRdData)
         && squashNext == ($past(memRdData) != 8'h00))
      else $error("nonzero skip wrong");
   swap_mem_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (doExec && opCode == OP_SWAP) |=> memWrEn && memWrData == {$past(memRdData[3:0]), $past(memRdData[7:4])}
         && $stable(flagsOut))
      else $error("nibble swap wrong");
   orm_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (doExec && opCode == OP_ORM) |=> flagsOut[FLAG_Z] == (memWrData == 8'h00)
         && flagsOut[FLAG_C] == $past(flagsOut[FLAG_C]))
      else $error("or-to-memory flags wrong");
   full_addr_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      doExec |=> memWrAddr == $past(memAddr))
      else $error("write address not the full operand address");
endmodule

// [xmo_execute_tb.sv]
`timescale 1ns/1ps
// self-checking testbench for the extended memory-op execute block
module xmo_execute_tb;
   import xmo_pkg::*;
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic        opValid = 1'b0;
   xmo_op_type  opCode = OP_NOP;
   logic [2:0]  bitSel = 3'h0;
   logic [11:0] memAddr = 12'habc;
   logic [7:0]  memRdData = 8'h00;
   logic        memWrEn;
   logic [11:0] memWrAddr;
   logic [7:0]  memWrData;
   logic [7:0]  accOut;
   logic [5:0]  flagsOut;
   logic        squashNext;
   logic        busy;
   int          miscompares = 0;
   int          samples_checked = 0;
   int          cycles = 0;

   xmo_execute uut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .opValid(opValid), .opCode(opCode), .bitSel(bitSel),
      .memAddr(memAddr), .memRdData(memRdData), .memWrEn(memWrEn), .memWrAddr(memWrAddr),
      .memWrData(memWrData), .accOut(accOut), .flagsOut(flagsOut), .squashNext(squashNext), .busy(busy)
   );

   always #20 clk_sys = ~clk_sys;

   task automatic results;
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // the whole run needs about a hundred cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         results();
      end
   end

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
         miscompares++;
      end
   endtask

   // one instruction; afterwards a follower op is presented (set-byte while a skip should block it)
   task automatic exec(input xmo_op_type op, input logic [7:0] m, input logic [2:0] b, input logic s);
      @(negedge clk_sys);
      opValid = 1'b1;
      opCode = op;
      memRdData = m;
      bitSel = b;
      memAddr = memAddr + 12'h111;
      @(negedge clk_sys);
      opCode = s ? OP_SET : OP_NOP;
      memRdData = ~m;
   endtask

   task automatic mw(input logic [7:0] d);
      chk("memWrEn", 8'h01, {7'h00, memWrEn});
      chk("memWrData", d, memWrData);
      chk("memWrAddrLo", memAddr[7:0], memWrAddr[7:0]);
      chk("memWrAddrHi", {4'h0, memAddr[11:8]}, {4'h0, memWrAddr[11:8]});
   endtask

   task automatic ac(input logic [7:0] a);
      chk("memWrEn", 8'h00, {7'h00, memWrEn});
      chk("accOut", a, accOut);
   endtask

   task automatic fl(input logic [5:0] f);
      chk("flagsOut", {2'b00, f}, {2'b00, flagsOut});
   endtask

   task automatic sk(input logic s);
      chk("squashNext", {7'h00, s}, {7'h00, squashNext});
      chk("busy", {7'h00, s}, {7'h00, busy});
      if (s) begin
         @(negedge clk_sys);
         chk("dummyWrEn", 8'h00, {7'h00, memWrEn});
         chk("dummySquash", 8'h01, {7'h00, squashNext});
         @(negedge clk_sys);
         opCode = OP_NOP;
         chk("skipEndBusy", 8'h00, {7'h00, busy});
         chk("skipEndWrEn", 8'h00, {7'h00, memWrEn});
      end
   endtask

   task automatic t_reset;
      ac(8'h00);
      fl(6'h00);
      sk(1'b0);
   endtask

   task automatic t_subtract;
      exec(OP_SWAP_A, 8'h01, 3'h0, 1'b0); ac(8'h10);
      exec(OP_SUB_A, 8'h01, 3'h0, 1'b0); ac(8'h0f); fl(6'h01);
      exec(OP_SBC_A, 8'h0f, 3'h0, 1'b0); ac(8'h00); fl(6'h07);
      exec(OP_SBC_M, 8'h01, 3'h0, 1'b0); mw(8'hff); fl(6'h10);
      chk("accKept", 8'h00, accOut);
      exec(OP_SUB_M, 8'h80, 3'h0, 1'b0); mw(8'h80); fl(6'h0a);
      exec(OP_SBC_A, 8'h00, 3'h0, 1'b0); ac(8'hff); fl(6'h10);
      exec(OP_SUB_A, 8'hff, 3'h0, 1'b0); ac(8'h00); fl(6'h27);
      exec(OP_SBC_A, 8'h00, 3'h0, 1'b0); ac(8'h00); fl(6'h27);
   endtask

   task automatic t_rotate;
      exec(OP_ROL, 8'h81, 3'h0, 1'b0); mw(8'h03); fl(6'h27);
      exec(OP_ROL_A, 8'h81, 3'h0, 1'b0); ac(8'h03); fl(6'h27);
      exec(OP_ROR, 8'h81, 3'h0, 1'b0); mw(8'hc0); fl(6'h27);
      exec(OP_ROR_A, 8'h81, 3'h0, 1'b0); ac(8'hc0); fl(6'h27);
   endtask

   task automatic t_carry;
      exec(OP_ROLC_A, 8'h00, 3'h0, 1'b0); ac(8'h01); fl(6'h26);
      exec(OP_ROLC, 8'h81, 3'h0, 1'b0); mw(8'h02); fl(6'h27);
      exec(OP_RORC_A, 8'h00, 3'h0, 1'b0); ac(8'h80); fl(6'h26);
      exec(OP_RORC, 8'h03, 3'h0, 1'b0); mw(8'h01); fl(6'h27);
   endtask

   task automatic t_skip;
      exec(OP_DECSZ, 8'h01, 3'h0, 1'b1); mw(8'h00); sk(1'b1);
      exec(OP_DECSZ, 8'h02, 3'h0, 1'b0); mw(8'h01); sk(1'b0);
      exec(OP_DECSZ_A, 8'h01, 3'h0, 1'b1); ac(8'h00); sk(1'b1);
      exec(OP_INCSZ, 8'hff, 3'h0, 1'b1); mw(8'h00); sk(1'b1);
      exec(OP_INCSZ_A, 8'hfe, 3'h0, 1'b0); ac(8'hff); sk(1'b0);
      exec(OP_INCSZ_A, 8'hff, 3'h0, 1'b1); ac(8'h00); sk(1'b1);
      exec(OP_SNZBIT, 8'h08, 3'h3, 1'b1); sk(1'b1);
      exec(OP_SNZBIT, 8'hf7, 3'h3, 1'b0); sk(1'b0);
      exec(OP_SNZ, 8'h05, 3'h0, 1'b1); mw(8'h05); sk(1'b1);
      exec(OP_SNZ, 8'h00, 3'h0, 1'b0); mw(8'h00); sk(1'b0);
      fl(6'h27);
   endtask

   task automatic t_misc;
      exec(OP_SET, 8'h12, 3'h0, 1'b0); mw(8'hff); fl(6'h27);
      for (int i = 0; i < 8; i++) begin
         exec(OP_SETBIT, 8'h00, 3'(i), 1'b0); mw(8'h01 << i);
      end
      exec(OP_SETBIT, 8'h5a, 3'h0, 1'b0); mw(8'h5b); fl(6'h27);
      exec(OP_SWAP, 8'h3c, 3'h0, 1'b0); mw(8'hc3); fl(6'h27);
      exec(OP_SWAP_A, 8'h5a, 3'h0, 1'b0); ac(8'ha5); fl(6'h27);
      exec(OP_ORM, 8'h0a, 3'h0, 1'b0); mw(8'haf); fl(6'h23);
      exec(OP_SWAP_A, 8'h00, 3'h0, 1'b0); ac(8'h00);
      exec(OP_ORM, 8'h00, 3'h0, 1'b0); mw(8'h00); fl(6'h27);
   endtask

   initial begin
      repeat (8) @(negedge clk_sys);
      sys_rst = 1'b0;
      t_reset();
      t_subtract();
      t_rotate();
      t_carry();
      t_skip();
      t_misc();
      results();
   end
endmodule
